// *** mlsg_guard.sv ***
// The address-and-strobe port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
module mlsg_guard
  import mlsg_pkg::*;
#(
  parameter int unsigned LOCK_OFF    = LOCK_OFF_CYC,
  parameter int unsigned EST_TIMEOUT = ETO_CYC,
  parameter int unsigned IND_DELAY   = IND_DLY_CYC
) (
  input  wire logic        CLK_SYS,
  input  wire logic        RST,
  input  wire logic        CE,
  input  wire logic [3:0]  REG_ADDR,
  input  wire logic [31:0] REG_WDATA,
  input  wire logic        REG_WR,
  input  wire logic        REG_RD,
  output logic      [31:0] REG_RDATA,
  input  mlsg_sense_s      SENSE,
  input  mlsg_gate_s       DRIVE,
  input  wire logic [11:0] CMD_AMP,
  input  wire logic        TACH_IN,
  output mlsg_gate_s       GATE,
  output logic      [11:0] BUF_AMP,
  output logic             TACH_OUT,
  output logic             MOTOR_RESTART
);
  // =========================================================
  // state
  typedef struct packed {
    mlsg_fsm_e   fsm;
    logic [31:0] ctrl;
    logic [31:0] motor;
    logic        stall_flag;
    logic [5:0]  cause;
    logic [23:0] cnt;
    logic [23:0] eto1;
    logic [23:0] eto2;
    logic [31:0] acc;
    logic [15:0] ktc;
    logic        ktc_vld;
    logic        ol_armed;
    logic        ol_zc;
    logic [23:0] cper;
    logic [23:0] pper;
    logic [13:0] pwm_cnt;
    logic        pwm_prev;
    logic        pwm_hi;
    logic        pwm_lo;
    logic [7:0]  dt_cnt;
    mlsg_gate_s  gate;
    logic [11:0] buf_amp;
    logic        tach;
    logic        restart;
    logic [31:0] rdata;
  } mlsg_state_s;

  mlsg_state_s s_reg;
  mlsg_state_s s_next;

  // a strictly above twice b
  function automatic logic over_dbl(input logic [24:0] a, input logic [24:0] b);
    return {1'b0, a} > {b, 1'b0};
  endfunction

  // =========================================================
  // configuration decode
  logic [5:0]  det_en;
  logic        mech_en;
  logic        ind_en;
  logic        mech_mode;
  logic        pwm_rate_double;
  logic [3:0]  dead_sel;
  logic [2:0]  stall_trip_current_sel;
  logic [1:0]  constant_window_sel;
  logic        run_en;
  logic [6:0]  rm_set;
  logic [6:0]  kt_set;
  assign det_en                 = s_reg.ctrl[CTRL_EN_LSB +: 6];
  assign mech_en                = s_reg.ctrl[CTRL_MECH];
  assign ind_en                 = s_reg.ctrl[CTRL_IND];
  assign mech_mode              = s_reg.ctrl[CTRL_MMODE];
  assign pwm_rate_double        = s_reg.ctrl[CTRL_DBL];
  assign dead_sel               = s_reg.ctrl[CTRL_DT_LSB +: 4];
  assign stall_trip_current_sel = s_reg.ctrl[CTRL_TRIP_LSB +: 3];
  assign constant_window_sel    = s_reg.ctrl[CTRL_WIN_LSB +: 2];
  assign run_en                 = s_reg.ctrl[CTRL_RUN];
  assign rm_set                 = s_reg.motor[MOTOR_RM_LSB +: 7];
  assign kt_set                 = s_reg.motor[MOTOR_KT_LSB +: 7];

  // =========================================================
  // detector conditions
  logic [11:0] trip_lvl;
  logic [12:0] bemf_k;
  logic [12:0] ir_drop;
  logic [11:0] bemf_sat;
  logic        speed_bad;
  logic [16:0] kt_ref;
  logic [16:0] kt_margin;
  logic [16:0] constant_window_low;
  logic [16:0] constant_window_high;
  logic        ktc_bad;
  logic [5:0]  det_raw;
  logic        fault;
  logic        guard_on;

  // trip level in 500 mA steps
  assign trip_lvl = 12'((int'(stall_trip_current_sel) + 1) * TRIP_STEP_MA);
  // back-EMF from speed and constant, drop from current and resistance
  assign bemf_k   = 13'((23'(SENSE.speed) * 23'(kt_set)) >> KT_SHIFT);
  assign ir_drop  = 13'((19'(SENSE.u_ma) * 19'(rm_set)) >> RM_SHIFT);
  assign bemf_sat = bemf_k[12] ? 12'hFFF : bemf_k[11:0];
  assign speed_bad = over_dbl(25'(bemf_k) + 25'(ir_drop), 25'(s_reg.buf_amp));
  // window around programmed constant
  assign kt_ref    = 17'(kt_set) << KTC_SHIFT;
  assign kt_margin = kt_ref >> (int'(constant_window_sel) + 1);
  assign constant_window_low  = kt_ref - kt_margin;
  assign constant_window_high = kt_ref + kt_margin;
  assign ktc_bad = s_reg.ktc_vld && (17'(s_reg.ktc) < constant_window_low ||
                                     17'(s_reg.ktc) > constant_window_high);

  // raw detector outputs, enables applied separately
  always_comb begin
    det_raw    = '0;
    det_raw[0] = SENSE.lowside_ma > trip_lvl;
    det_raw[1] = speed_bad && s_reg.eto1 >= 24'(EST_TIMEOUT - 1);
    det_raw[2] = ktc_bad && s_reg.eto2 >= 24'(EST_TIMEOUT - 1);
    det_raw[3] = SENSE.handoff && SENSE.u_ma <= 12'(NOMOTOR_MA);
    det_raw[4] = SENSE.ol_mode && s_reg.ol_armed && SENSE.ol_ecycle && !s_reg.ol_zc;
    det_raw[5] = !SENSE.ol_mode && s_reg.pper != '0 &&
                 over_dbl(25'(s_reg.cper) + 25'd1, 25'(s_reg.pper));
  end
  assign fault    = s_reg.fsm == MG_RUN && |(det_raw & det_en);
  // mechanical guard gating by mode and supply
  assign guard_on = mech_en && (!mech_mode || SENSE.supply >= 8'(SURGE_CODE));

  // =========================================================
  // next state
  logic [13:0] period;
  logic [13:0] duty_cyc;
  logic        pwm_raw;
  logic [7:0]  dead_cyc;
  always_comb begin
    period   = pwm_rate_double ? 14'(PWM_PERIOD_CYC / 2) : 14'(PWM_PERIOD_CYC);
    duty_cyc = 14'((26'(period) * 26'(s_reg.buf_amp)) >> 12);
    pwm_raw  = s_reg.pwm_cnt < duty_cyc;
    dead_cyc = 8'((int'(dead_sel) + 1) * DT_STEP_CYC);
    s_next         = s_reg;
    s_next.restart = 1'b0;
    s_next.rdata   = '0;

    // register writes
    if (REG_WR) begin
      case (REG_ADDR)
        ADDR_CTRL:  s_next.ctrl  = REG_WDATA & CTRL_MASK;
        ADDR_MOTOR: s_next.motor = REG_WDATA & MOTOR_MASK;
        default:    ;
      endcase
    end
    // register reads, data one cycle later
    if (REG_RD) begin
      case (REG_ADDR)
        ADDR_CTRL:   s_next.rdata = s_reg.ctrl;
        ADDR_MOTOR:  s_next.rdata = s_reg.motor;
        ADDR_STATUS: begin
          s_next.rdata[0] = s_reg.stall_flag;
          s_next.rdata[1] = s_reg.fsm != MG_RUN;
          s_next.rdata[STAT_CAUSE_LSB +: 6] = s_reg.cause;
        end
        ADDR_AMP:    s_next.rdata = 32'(s_reg.buf_amp);
        default:     s_next.rdata = '0;
      endcase
    end

    // timeout counters for the two estimate detectors
    s_next.eto1 = (speed_bad && s_reg.eto1 != 24'hFF_FFFF) ? s_reg.eto1 + 24'd1 :
                  (speed_bad ? s_reg.eto1 : '0);
    s_next.eto2 = (ktc_bad && s_reg.eto2 != 24'hFF_FFFF) ? s_reg.eto2 + 24'd1 :
                  (ktc_bad ? s_reg.eto2 : '0);

    // half-cycle back-EMF integration
    if (SENSE.zc) begin
      s_next.ktc     = 16'(s_reg.acc >> ACC_SHIFT);
      s_next.ktc_vld = 1'b1;
      s_next.acc     = 32'(SENSE.bemf_smp);
    end else begin
      s_next.acc = s_reg.acc + 32'(SENSE.bemf_smp);
    end

    // open loop window per electrical cycle
    if (!SENSE.ol_mode) begin
      s_next.ol_armed = 1'b0;
      s_next.ol_zc    = 1'b0;
    end else if (SENSE.ol_ecycle) begin
      s_next.ol_armed = s_reg.ol_armed || SENSE.ol_rate_over;
      s_next.ol_zc    = SENSE.zc;
    end else if (SENSE.zc) begin
      s_next.ol_zc = 1'b1;
    end

    // commutation period tracking
    if (SENSE.ol_mode) begin
      s_next.cper = '0;
      s_next.pper = '0;
    end else if (SENSE.commut) begin
      s_next.pper = s_reg.cper + 24'd1;
      s_next.cper = '0;
    end else if (s_reg.cper != 24'hFF_FFFF) begin
      s_next.cper = s_reg.cper + 24'd1;
    end

    // fault and restart sequencing
    unique case (s_reg.fsm)
      MG_IDLE: begin
        if (run_en) begin
          s_next.fsm = MG_RUN;
          s_next.restart = 1'b1;
        end
      end
      MG_RUN: begin
        s_next.cause = s_reg.cause | det_raw;
        if (fault) begin
          s_next.stall_flag = 1'b1;
        end
        if (fault || !run_en) begin
          s_next.cnt = '0;
          // inductive guard inserts the high-side-first phase
          if (ind_en) begin
            s_next.fsm = MG_SURGE;
          end else begin
            s_next.fsm = fault ? MG_LOCKOFF : MG_IDLE;
          end
        end
      end
      MG_SURGE: begin
        s_next.cnt = s_reg.cnt + 24'd1;
        if (s_reg.cnt >= 24'(IND_DELAY - 1)) begin
          s_next.cnt = '0;
          s_next.fsm = s_reg.stall_flag ? MG_LOCKOFF : MG_IDLE;
        end
      end
      MG_LOCKOFF: begin
        s_next.cnt = s_reg.cnt + 24'd1;
        if (!run_en) begin
          s_next.fsm = MG_IDLE;
        end else if (s_reg.cnt >= 24'(LOCK_OFF - 1)) begin
          s_next.fsm     = MG_RUN;
          s_next.restart = 1'b1;
        end
      end
    endcase

    // restart clears causes, flag and detector history
    if (s_next.restart) begin
      s_next.cause      = '0;
      s_next.stall_flag = 1'b0;
      s_next.ktc_vld    = 1'b0;
      s_next.eto1       = '0;
      s_next.eto2       = '0;
      s_next.pper       = '0;
      s_next.cper       = '0;
      s_next.ol_armed   = 1'b0;
    end

    // pwm carrier and dead time
    s_next.pwm_cnt  = (s_reg.pwm_cnt >= period - 14'd1) ? '0 : s_reg.pwm_cnt + 14'd1;
    s_next.pwm_prev = pwm_raw;
    if (pwm_raw != s_reg.pwm_prev) begin
      s_next.pwm_hi = 1'b0;
      s_next.pwm_lo = 1'b0;
      s_next.dt_cnt = dead_cyc - 8'd1;
    end else if (s_reg.dt_cnt != '0) begin
      s_next.dt_cnt = s_reg.dt_cnt - 8'd1;
    end else begin
      s_next.pwm_hi = pwm_raw;
      s_next.pwm_lo = !pwm_raw;
    end

    // mechanical guard floor on the applied amplitude
    s_next.buf_amp = (guard_on && bemf_sat > CMD_AMP) ? bemf_sat : CMD_AMP;

    // gate drive follows the new sequencing state
    s_next.gate = '0;
    unique case (s_next.fsm)
      MG_RUN: begin
        s_next.gate.hs = DRIVE.hs & {3{s_reg.pwm_hi}};
        s_next.gate.ls = DRIVE.ls | (DRIVE.hs & {3{s_reg.pwm_lo}});
      end
      MG_SURGE: s_next.gate.ls = DRIVE.ls;
      MG_IDLE, MG_LOCKOFF: s_next.gate = '0;
    endcase

    // tach held high while stalled
    s_next.tach = s_next.stall_flag ? 1'b1 : TACH_IN;
  end

  // =========================================================
  // state register with clock enable
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      s_reg       <= '0;
      s_reg.ctrl  <= CTRL_RST;
      s_reg.motor <= MOTOR_RST;
    end else if (CE) begin
      s_reg <= s_next;
    end
  end

  // =========================================================
  // outputs
  assign REG_RDATA     = s_reg.rdata;
  assign GATE          = s_reg.gate;
  assign BUF_AMP       = s_reg.buf_amp;
  assign TACH_OUT      = s_reg.tach;
  assign MOTOR_RESTART = s_reg.restart;

  // =========================================================
  // assertions
  a_cause_even_off:
  assert property (@(posedge CLK_SYS) disable iff (RST)
    CE && s_reg.fsm == MG_RUN && det_raw[0] && !det_en[0] |=> s_reg.cause[0])
    else $error("cause bit not set for disabled detector");

  a_disabled_no_stop:
  assert property (@(posedge CLK_SYS) disable iff (RST)
    CE && s_reg.fsm == MG_RUN && run_en && (det_raw & det_en) == '0 |=> s_reg.fsm == MG_RUN)
    else $error("drive stopped without enabled detection");

  a_fault_sets_flag:
  assert property (@(posedge CLK_SYS) disable iff (RST)
    CE && fault |=> s_reg.stall_flag && s_reg.fsm != MG_RUN)
    else $error("fault did not flag and stop drive");

  a_surge_hs_off:
  assert property (@(posedge CLK_SYS) disable iff (RST)
    $past(CE) && s_reg.fsm == MG_SURGE |-> GATE.hs == '0 && GATE.ls == $past(DRIVE.ls))
    else $error("surge phase gate pattern wrong");

  a_surge_length:
  assert property (@(posedge CLK_SYS) disable iff (RST)
    CE && fault && ind_en ##1 CE [*2] |-> s_reg.fsm == MG_SURGE || IND_DELAY < 3)
    else $error("surge phase skipped");

  a_lockoff_hiz:
  assert property (@(posedge CLK_SYS) disable iff (RST)
    s_reg.fsm == MG_LOCKOFF |-> GATE == '0)
    else $error("drivers active during lock-off");

  a_restart_clears:
  assert property (@(posedge CLK_SYS) disable iff (RST)
    MOTOR_RESTART |-> s_reg.cause == '0 && !s_reg.stall_flag && s_reg.fsm == MG_RUN)
    else $error("restart left fault state");

  a_no_motor:
  assert property (@(posedge CLK_SYS) disable iff (RST)
    CE && s_reg.fsm == MG_RUN && SENSE.handoff && SENSE.u_ma <= 12'(NOMOTOR_MA) |=> s_reg.cause[3])
    else $error("missing motor not reported");

  a_guard_floor:
  assert property (@(posedge CLK_SYS) disable iff (RST)
    $past(CE) && $past(guard_on) |-> BUF_AMP >= $past(bemf_sat))
    else $error("amplitude below back-EMF with guard on");

  a_tach_stall:
  assert property (@(posedge CLK_SYS) disable iff (RST)
    s_reg.stall_flag |-> TACH_OUT)
    else $error("tach not high while stalled");
endmodule

// *** mlsg_pkg.sv ***
// Contract
// - six enable bits, one per detector; cleared bit blocks that detector's shutdown
// - any enabled stall or missing-motor detection sets the stall flag
// - six fault cause bits show which detector fired; cleared on restart
// - a cause bit sets even when its detector is disabled
// - stall or missing-motor fault puts all phase drivers in high impedance
// - every entry into high impedance passes through the anti-surge sequence
// - after a fault, wait the lock-off time, then restart automatically
// - low-side current above three-bit threshold trips, flags stall, retries later
// - back-EMF from current and resistance, speed and constant; trip if far above amplitude
// - integrated half-cycle back-EMF outside two-bit window for timeout declares stall
// - after open-to-closed handoff, U current not above 140 mA means no motor
// - open loop above handoff rate, no back-EMF in one electrical cycle stalls
// - closed loop commutation period above twice the previous one stalls
// - mechanical and inductive surge guards each have their own enable
// - mechanical guard keeps applied amplitude at or above computed back-EMF
// - mode 0 guard always on; mode 1 only once supply reaches 24 V
// - inductive guard: high sides off first, conducting low sides off after delay
// - four-bit dead time selects 16 gaps from 40 ns to 640 ns
// - PWM runs at 25 kHz, or 50 kHz with the rate-double bit set
// - tachometer output held high while a stall is in effect
package mlsg_pkg;
  // =========================================================
  // timing
  localparam int CLK_MHZ        = 250;
  localparam int LOCK_OFF_US    = 4000;
  localparam int LOCK_OFF_CYC   = LOCK_OFF_US * CLK_MHZ;
  localparam int ETO_US         = 1000;
  localparam int ETO_CYC        = ETO_US * CLK_MHZ;
  localparam int IND_DLY_NS     = 2000;
  localparam int IND_DLY_CYC    = (IND_DLY_NS * CLK_MHZ + 999) / 1000;
  localparam int DT_STEP_NS     = 40;
  localparam int DT_STEP_CYC    = (DT_STEP_NS * CLK_MHZ + 999) / 1000;
  localparam int PWM_BASE_KHZ   = 25;
  localparam int PWM_PERIOD_CYC = CLK_MHZ * 1000 / PWM_BASE_KHZ;
  // =========================================================
  // analog levels and scaling
  localparam int NOMOTOR_MA   = 140;
  localparam int TRIP_STEP_MA = 500;
  localparam int SURGE_MV     = 24000;
  localparam int SUPPLY_FS_MV = 30000;
  localparam int SURGE_CODE   = (SURGE_MV * 256 + SUPPLY_FS_MV - 1) / SUPPLY_FS_MV;
  localparam int KT_SHIFT     = 10;
  localparam int RM_SHIFT     = 6;
  localparam int KTC_SHIFT    = 4;
  localparam int ACC_SHIFT    = 16;
  // =========================================================
  // register map and fields
  localparam logic [3:0]  ADDR_CTRL   = 4'h0;
  localparam logic [3:0]  ADDR_MOTOR  = 4'h4;
  localparam logic [3:0]  ADDR_STATUS = 4'h8;
  localparam logic [3:0]  ADDR_AMP    = 4'hC;
  localparam int CTRL_EN_LSB = 0;
  localparam int CTRL_MECH   = 6;
  localparam int CTRL_IND    = 7;
  localparam int CTRL_MMODE  = 8;
  localparam int CTRL_DBL    = 9;
  localparam int CTRL_DT_LSB = 10;
  localparam int CTRL_TRIP_LSB = 14;
  localparam int CTRL_WIN_LSB  = 17;
  localparam int CTRL_RUN      = 19;
  localparam int MOTOR_RM_LSB  = 0;
  localparam int MOTOR_KT_LSB  = 8;
  localparam int STAT_CAUSE_LSB = 8;
  localparam logic [31:0] CTRL_RST   = 32'h0000_00FF;
  localparam logic [31:0] CTRL_MASK  = 32'h000F_FFFF;
  localparam logic [31:0] MOTOR_RST  = 32'h0000_2010;
  localparam logic [31:0] MOTOR_MASK = 32'h0000_7F7F;
  // =========================================================
  // types
  typedef enum logic [1:0] {MG_IDLE, MG_RUN, MG_SURGE, MG_LOCKOFF} mlsg_fsm_e;
  typedef struct packed {
    logic [11:0] lowside_ma;
    logic [11:0] u_ma;
    logic [15:0] speed;
    logic [7:0]  supply;
    logic [11:0] bemf_smp;
    logic        zc;
    logic        ol_mode;
    logic        ol_rate_over;
    logic        ol_ecycle;
    logic        handoff;
    logic        commut;
  } mlsg_sense_s;
  typedef struct packed {
    logic [2:0] hs;
    logic [2:0] ls;
  } mlsg_gate_s;
endpackage

// *** mlsg_bridge.sv ***
`timescale 1ns/1ps
module mlsg_bridge
  import mlsg_pkg::*;
(
  input  wire logic        clk,
  input  mlsg_gate_s       gate,
  input  wire logic [11:0] load_ma,
  output logic      [11:0] lowside_ma,
  output logic      [11:0] u_ma
);
  // ==========================================================
  // winding current model
  logic [13:0] hold_reg = 14'h0000;
  // current keeps flowing for 12000 cycles, 1.2 pwm periods, after the last switching
  always_ff @(posedge clk) begin
    if (gate != '0) begin
      hold_reg <= 14'h2EE0;
    end else if (hold_reg != '0) begin
      hold_reg <= hold_reg - 14'h0001;
    end
  end
  // sensed currents read zero once the winding has decayed
  assign lowside_ma = (hold_reg != '0) ? load_ma : 12'h0000;
  assign u_ma       = lowside_ma;
endmodule

// *** testbench.sv ***
`timescale 1ns/1ps
module testbench
  import mlsg_pkg::*;
;
  // ==========================================================
  // signals
  logic        clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, ho = 1'b0, cm = 1'b0, ce = 1'b1;
  logic [3:0]  addr = 4'h0;
  logic [31:0] wdata = 32'h0000_0000, rdata_w, st;
  logic [15:0] spd = 16'h0000;
  logic [7:0]  sup = 8'h64;
  logic [11:0] cmd_amp = 12'h800, load = 12'h000, buf_amp, lo_ma, u_ma;
  logic        tach, restart;
  mlsg_sense_s sense;
  mlsg_gate_s  drive = '{hs: 3'b001, ls: 3'b100};
  mlsg_gate_s  gate;
  int          gap = 0, n_errors = 0, num_checks = 0;
  // sense bundle, unused detector inputs held quiet
  assign sense = {lo_ma, u_ma, spd, sup, 12'h000, 4'h0, ho, cm};
  mlsg_guard #(.LOCK_OFF(50), .EST_TIMEOUT(20), .IND_DELAY(4)) mlsg_guard_i (
    .CLK_SYS(clk), .RST(rst), .CE(ce), .REG_ADDR(addr), .REG_WDATA(wdata), .REG_WR(wr),
    .REG_RD(rd), .REG_RDATA(rdata_w), .SENSE(sense), .DRIVE(drive), .CMD_AMP(cmd_amp),
    .TACH_IN(1'b0), .GATE(gate), .BUF_AMP(buf_amp), .TACH_OUT(tach), .MOTOR_RESTART(restart));
  mlsg_bridge mlsg_bridge_i (.clk(clk), .gate(gate), .load_ma(load), .lowside_ma(lo_ma), .u_ma(u_ma));
  // clock and commutation pulse source
  initial forever #2 clk = ~clk;
  always begin
    if (gap != 0) begin
      repeat (gap) @(posedge clk);
      cm <= 1'b1;
      @(posedge clk);
      cm <= 1'b0;
    end else begin
      @(posedge clk);
    end
  end
  // ==========================================================
  // helpers
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk); addr <= a; wdata <= d; wr <= 1'b1;
    @(posedge clk); wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk); addr <= a; rd <= 1'b1;
    @(posedge clk); rd <= 1'b0;
    #1 d = rdata_w;
  endtask
  // dead sel 9 gives 400 ns, trip sel 0 kept above acceleration limit
  function automatic logic [31:0] cfg(input logic [5:0] en, input logic m, i, md, r);
    return {12'h000, r, 5'h00, 4'h9, 1'b0, md, i, m, en};
  endfunction
  task automatic wait_rs(output int n);
    n = 0;
    do begin
      @(posedge clk); #1 n++;
    end while (restart !== 1'b1 && n < 300);
    chk("restart pulse", 32'h1, {31'h0, restart});
  endtask
  task automatic start(input logic [5:0] en, input logic m, i, md);
    int n;
    wr_reg(ADDR_CTRL, cfg(en, m, i, md, 1'b1));
    wait_rs(n);
    chk("start latency", 32'h1, {31'h0, n == 1});
  endtask
  task automatic stop();
    wr_reg(ADDR_CTRL, cfg(6'h00, 1'b0, 1'b0, 1'b0, 1'b0));
    repeat (20) @(posedge clk);
  endtask
  task automatic pulse_ho();
    @(posedge clk); ho <= 1'b1;
    @(posedge clk); ho <= 1'b0;
    repeat (3) @(posedge clk);
  endtask
  // ==========================================================
  // scenarios
  task automatic t_reset();
    rd_reg(ADDR_CTRL, st);  chk("ctrl reset", CTRL_RST, st);
    rd_reg(ADDR_MOTOR, st); chk("motor reset", MOTOR_RST, st);
    rd_reg(4'h2, st);       chk("unmapped read", 32'h0000_0000, st);
    // a write while the clock enable is low is lost
    ce <= 1'b0;
    wr_reg(ADDR_CTRL, 32'h0000_0000);
    ce <= 1'b1;
    rd_reg(ADDR_CTRL, st);  chk("frozen write", CTRL_RST, st);
  endtask
  task automatic t_trip(input logic ind);
    int n;
    start(6'h01, 1'b1, ind, 1'b0);
    repeat (200) @(posedge clk);
    load <= 12'h320;
    @(posedge clk);
    @(posedge clk); #1;
    chk("hs off", 32'h0, {29'h0, gate.hs});
    chk("ls held", {29'h0, ind ? drive.ls : 3'b000}, {29'h0, gate.ls});
    chk("tach high", 32'h1, {31'h0, tach});
    rd_reg(ADDR_STATUS, st);
    chk("stall flag", 32'h1, {31'h0, st[0]});
    chk("cause", 32'h01, {26'h0, st[13:8]} & 32'h01);
    repeat (4) @(posedge clk); #1;
    chk("all off", 32'h0, {26'h0, gate});
    load <= 12'h000;
    wait_rs(n);
    chk("lock off span", 32'h1, {31'h0, n >= 40 && n <= 60});
    rd_reg(ADDR_STATUS, st);
    chk("cleared", 32'h0, {26'h0, st[13:8]} & 32'h01 | {31'h0, st[0]});
    stop();
  endtask
  task automatic t_disabled();
    start(6'h00, 1'b1, 1'b1, 1'b0);
    repeat (200) @(posedge clk);
    load <= 12'h320;
    repeat (4) @(posedge clk);
    rd_reg(ADDR_STATUS, st);
    chk("no shutdown", 32'h0, {30'h0, st[1:0]});
    chk("cause anyway", 32'h1, {31'h0, st[8]});
    load <= 12'h000;
    stop();
  endtask
  task automatic t_nomotor();
    int n;
    start(6'h08, 1'b1, 1'b1, 1'b0);
    repeat (200) @(posedge clk);
    load <= 12'h12C;
    pulse_ho();
    rd_reg(ADDR_STATUS, st); chk("motor present", 32'h0, {31'h0, st[0]});
    load <= 12'h064;
    pulse_ho();
    rd_reg(ADDR_STATUS, st); chk("no motor", 32'h9, {28'h0, st[11:8]} & 32'h8 | {31'h0, st[0]});
    load <= 12'h000;
    wait_rs(n);
    stop();
  endtask
  task automatic t_closed();
    start(6'h00, 1'b1, 1'b1, 1'b0);
    gap = 10;
    repeat (60) @(posedge clk);
    wr_reg(ADDR_CTRL, cfg(6'h20, 1'b1, 1'b1, 1'b0, 1'b1));
    repeat (30) @(posedge clk);
    rd_reg(ADDR_STATUS, st); chk("steady period", 32'h0, {31'h0, st[0]});
    gap = 40;
    repeat (50) @(posedge clk);
    rd_reg(ADDR_STATUS, st); chk("period doubled", 32'h21, {26'h0, st[13:8]} & 32'h20 | {31'h0, st[0]});
    gap = 0;
    stop();
  endtask
  task automatic t_mech();
    start(6'h00, 1'b1, 1'b0, 1'b0);
    spd <= 16'h2000;
    cmd_amp <= 12'h080;
    repeat (30) @(posedge clk); #1 chk("floor mode0", 32'h1, {31'h0, buf_amp >= 12'h100});
    wr_reg(ADDR_CTRL, cfg(6'h00, 1'b1, 1'b0, 1'b1, 1'b1));
    repeat (30) @(posedge clk); #1 chk("low supply", 32'h080, {20'h0, buf_amp});
    sup <= 8'hCD;
    repeat (30) @(posedge clk); #1 chk("high supply", 32'h1, {31'h0, buf_amp >= 12'h100});
    wr_reg(ADDR_CTRL, cfg(6'h00, 1'b0, 1'b0, 1'b0, 1'b1));
    repeat (30) @(posedge clk); #1 chk("guard off", 32'h080, {20'h0, buf_amp});
    spd <= 16'h0000;
    cmd_amp <= 12'h800;
    stop();
  endtask
  // ==========================================================
  // run control
  task automatic end_of_test();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    repeat (30000) @(posedge clk);
    n_errors++;
    end_of_test();
  end
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_trip(1'b1);
    t_trip(1'b0);
    t_disabled();
    t_nomotor();
    t_closed();
    t_mech();
    end_of_test();
  end
endmodule
